/* inc/rhs_map.vh */
// Offsets, field positions, reset values and sizes of the status-pin block
`ifndef RHS_MAP_VH
`define RHS_MAP_VH
`define RHS_ADDR_PINCFG  6'h1c
`define RHS_ADDR_SECCTL  6'h19
`define RHS_ADDR_DBGSEL  6'h1d
`define RHS_PINCFG_RST   16'h0040
`define RHS_SECCTL_RST   16'h0000
`define RHS_DBGSEL_RST   16'h0000
`define RHS_THR_MSB      6
`define RHS_THR_LSB      0
`define RHS_POL_FIFO     7
`define RHS_POL_RX_THRESHOLD_PIN    8
`define RHS_POL_SFD      9
`define RHS_POL_CCA      10
`define RHS_GUARD_BIT    9
`define RHS_DBG_SFD_MSB  1
`define RHS_DBG_SFD_LSB  0
`define RHS_DBG_CCA_MSB  3
`define RHS_DBG_CCA_LSB  2
`define RHS_BUF_DEPTH    8'h80
`endif

/* logic/rhs_sync.v */
// Two-flip-flop synchroniser for pin inputs
module rhs_sync
#(
	parameter W = 2
)
(
	input  wire         sys_clk,
	input  wire         rst,
	input  wire [W-1:0] asyncIn,
	output wire [W-1:0] syncOut
);
	genvar i;
	generate
		for (i = 0; i < W; i = i + 1)
		begin : gBit
			reg meta_ff;
			reg sync_ff;
			always @(posedge sys_clk or posedge rst)
			begin
				if (rst)
				begin
					meta_ff <= 1'b1;
					sync_ff <= 1'b1;
				end
				else
				begin
					meta_ff <= asyncIn[i];
					sync_ff <= meta_ff;
				end
			end
			assign syncOut[i] = sync_ff;
		end
	endgenerate
endmodule // rhs_sync

/* logic/rhs_rx_buffer.v */
// Receive byte buffer with frame discard, header guard and overflow flag
`include "rhs_map.vh"
module rhs_rx_buffer
(
	input  wire       sys_clk,
	input  wire       rst,
	input  wire       wrEn,
	input  wire [7:0] wrData,
	input  wire       frameStart,
	input  wire       discard,
	input  wire       protectHold,
	input  wire       protectRelease,
	input  wire       rdEn,
	input  wire       flush,
	output wire [7:0] rdData,
	output wire [7:0] count,
	output wire       overflow
);
	reg  [7:0] mem [0:127];
	reg  [7:0] wrPtr_ff;
	reg  [7:0] rdPtr_ff;
	reg  [7:0] fsPtr_ff;
	reg  [7:0] protBase_ff;
	reg        protOn_ff;
	reg        ovf_ff;
	reg  [7:0] rdData_ff;
	wire [7:0] occ;
	wire [7:0] guardSpan;
	wire       accept;
	wire       doRead;

	// Guarded header bytes still occupy space after they are read
	// Unread bytes ahead of the guarded frame must still count, so take the longer span
	assign guardSpan = wrPtr_ff - protBase_ff;
	assign occ       = (protOn_ff & (guardSpan > count)) ? guardSpan : count;
	assign count  = wrPtr_ff - rdPtr_ff;
	assign accept = wrEn & ~ovf_ff & (occ < `RHS_BUF_DEPTH);
	assign doRead = rdEn & (count != 8'h00);

	always @(posedge sys_clk)
	begin
		if (accept)
			mem[wrPtr_ff[6:0]] <= wrData;
	end

	always @(posedge sys_clk or posedge rst)
	begin
		if (rst)
		begin
			wrPtr_ff    <= 8'h00;
			rdPtr_ff    <= 8'h00;
			fsPtr_ff    <= 8'h00;
			protBase_ff <= 8'h00;
			protOn_ff   <= 1'b0;
			ovf_ff      <= 1'b0;
			rdData_ff   <= 8'h00;
		end
		else if (flush)
		begin
			wrPtr_ff  <= 8'h00;
			rdPtr_ff  <= 8'h00;
			fsPtr_ff  <= 8'h00;
			protOn_ff <= 1'b0;
			ovf_ff    <= 1'b0;
		end
		else
		begin
			if (discard)
				wrPtr_ff <= fsPtr_ff;
			else if (accept)
				wrPtr_ff <= wrPtr_ff + 8'h01;
			if (accept & frameStart)
				fsPtr_ff <= wrPtr_ff;
			// Overflow drops the byte; stored frames stay intact
			if (wrEn & ~ovf_ff & (occ >= `RHS_BUF_DEPTH))
				ovf_ff <= 1'b1;
			if (doRead)
			begin
				rdPtr_ff  <= rdPtr_ff + 8'h01;
				rdData_ff <= mem[rdPtr_ff[6:0]];
			end
			if (protectHold)
			begin
				protOn_ff   <= 1'b1;
				protBase_ff <= (accept & frameStart) ? wrPtr_ff : fsPtr_ff;
			end
			else if (protectRelease)
				protOn_ff <= 1'b0;
		end
	end

	assign rdData   = rdData_ff;
	assign overflow = ovf_ff;
endmodule // rhs_rx_buffer

/* logic/rhs_status_pins.v */
// Status pins, pin configuration and serial output stage of the radio
`include "rhs_map.vh"
module rhs_status_pins
(
	input  wire        sys_clk,
	input  wire        rst,
	input  wire        chipSelectLow,
	input  wire        serialClock,
	input  wire [7:0]  statusByte,
	input  wire        regWrEn,
	input  wire [5:0]  regAddr,
	input  wire [15:0] regWrData,
	output reg  [15:0] regRdData,
	input  wire        receiveFlushStrobe,
	input  wire        hostRead,
	output wire [7:0]  rdByte,
	input  wire        rxByteValid,
	input  wire [7:0]  rxByte,
	input  wire        rxLengthByte,
	input  wire        rxSfdDone,
	input  wire        rxLastByte,
	input  wire        addrFilterEn,
	input  wire        autoDiscardEn,
	input  wire        addrPass,
	input  wire        addrFail,
	input  wire        securedFrame,
	input  wire        decryptDone,
	input  wire        txMode,
	input  wire        txSfdDone,
	input  wire        txLastByte,
	input  wire        txUnderflow,
	input  wire        channelClearRaw,
	input  wire [2:0]  debugSignals,
	output reg         rxNonEmptyPin,
	output reg         rxThresholdPin,
	output reg         frameDelimiterTimingPin,
	output reg         channelClearPin,
	output reg         serialDataOut,
	output reg         serialDataOe
);
	localparam [2:0] ST_IDLE = 3'b001;
	localparam [2:0] ST_RXF  = 3'b010;
	localparam [2:0] ST_TXF  = 3'b100;

	reg  [15:0] pinCfg_ff;
	reg  [15:0] secCtl_ff;
	reg  [15:0] dbgSel_ff;
	reg  [2:0]  state_ff;
	reg  [2:0]  nxt_state;
	reg         passed_ff;
	reg         pktDone_ff;
	reg         sclkPrev_ff;
	reg         csPrev_ff;
	reg  [7:0]  soShift_ff;
	reg  [2:0]  soBit_ff;
	reg         sfdSrc;
	reg         ccaSrc;
	wire [1:0]  syncPins;
	wire        csLowS;
	wire        sclkS;
	wire [7:0]  count;
	wire        overflow;
	wire [6:0]  thr;
	wire        thrHit;
	wire        guardOn;
	wire        frameOk;
	wire        rxWr;
	wire        rxFlush;
	wire        popValid;
	wire        sclkFall;
	wire        csFall;
	wire        nonEmptyRaw;
	wire        thresholdRaw;

	rhs_sync #(.W(2)) uSync
	(
		.sys_clk (sys_clk),
		.rst     (rst),
		.asyncIn ({chipSelectLow, serialClock}),
		.syncOut (syncPins)
	);
	assign csLowS = syncPins[1];
	assign sclkS  = syncPins[0];

	assign guardOn = secCtl_ff[`RHS_GUARD_BIT];
	// Only receive-side traffic feeds the buffer and its pins
	assign rxWr    = rxByteValid & ~txMode;
	// A flush leaves a transmit frame in flight untouched
	assign rxFlush  = receiveFlushStrobe & ~txMode;
	assign popValid = hostRead & (count != 8'h00);

	rhs_rx_buffer uBuf
	(
		.sys_clk        (sys_clk),
		.rst            (rst),
		.wrEn           (rxWr),
		.wrData         (rxByte),
		.frameStart     (rxLengthByte),
		.discard        (addrFail & autoDiscardEn),
		.protectHold    (guardOn & securedFrame & rxLengthByte & rxWr),
		.protectRelease (decryptDone),
		.rdEn           (hostRead),
		.flush          (receiveFlushStrobe),
		.rdData         (rdByte),
		.count          (count),
		.overflow       (overflow)
	);

	// Register file; writes apply on the cycle the access is decoded
	always @(posedge sys_clk or posedge rst)
	begin
		if (rst)
			pinCfg_ff <= `RHS_PINCFG_RST;
		else if (regWrEn & (regAddr == `RHS_ADDR_PINCFG))
			pinCfg_ff <= regWrData;
	end

	always @(posedge sys_clk or posedge rst)
	begin
		if (rst)
			secCtl_ff <= `RHS_SECCTL_RST;
		else if (regWrEn & (regAddr == `RHS_ADDR_SECCTL))
			secCtl_ff <= regWrData;
	end

	always @(posedge sys_clk or posedge rst)
	begin
		if (rst)
			dbgSel_ff <= `RHS_DBGSEL_RST;
		else if (regWrEn & (regAddr == `RHS_ADDR_DBGSEL))
			dbgSel_ff <= regWrData;
	end

	always @(posedge sys_clk or posedge rst)
	begin
		if (rst)
			regRdData <= 16'h0000;
		else
		begin
			case (regAddr)
				`RHS_ADDR_PINCFG: regRdData <= pinCfg_ff;
				`RHS_ADDR_SECCTL: regRdData <= secCtl_ff;
				`RHS_ADDR_DBGSEL: regRdData <= dbgSel_ff;
				default:          regRdData <= 16'h0000;
			endcase
		end
	end

	// Frame delimiter timing state
	always @*
	begin
		nxt_state = state_ff;
		case (state_ff)
			ST_IDLE:
			begin
				if (txMode & txSfdDone)
					nxt_state = ST_TXF;
				else if (~txMode & rxSfdDone)
					nxt_state = ST_RXF;
			end
			ST_RXF:
			begin
				if (addrFail)
					nxt_state = ST_IDLE;
				else if (rxLastByte)
					nxt_state = ST_IDLE;
			end
			ST_TXF:
			begin
				if (txLastByte | txUnderflow)
					nxt_state = ST_IDLE;
			end
			default:
				nxt_state = ST_IDLE;
		endcase
	end

	// A flush outside transmit mode drops a frame in progress; after overflow the first flush
	// may race a late delimiter event, which is why two are advised
	always @(posedge sys_clk or posedge rst)
	begin
		if (rst)
			state_ff <= ST_IDLE;
		else if (rxFlush)
			state_ff <= ST_IDLE;
		else
			state_ff <= nxt_state;
	end

	// Address filter outcome for the frame being received
	always @(posedge sys_clk or posedge rst)
	begin
		if (rst)
			passed_ff <= 1'b0;
		else if (addrPass)
			passed_ff <= 1'b1;
		else if (receiveFlushStrobe | addrFail | (rxWr & rxLengthByte))
			passed_ff <= 1'b0;
	end

	// Packet-complete flag: set wins over the clearing read
	always @(posedge sys_clk or posedge rst)
	begin
		if (rst)
			pktDone_ff <= 1'b0;
		else if (rxLastByte & ~txMode)
			pktDone_ff <= 1'b1;
		else if (receiveFlushStrobe | popValid)
			pktDone_ff <= 1'b0;
	end

	assign thr     = pinCfg_ff[`RHS_THR_MSB:`RHS_THR_LSB];
	assign frameOk = ~addrFilterEn | passed_ff;
	assign thrHit  = (count > {1'b0, thr}) & frameOk;
	// Overflow shows as non-empty low with threshold high; a packet end that leaves the buffer empty makes the same pair
	assign nonEmptyRaw  = (count != 8'h00) & ~overflow;
	assign thresholdRaw = thrHit | pktDone_ff | overflow;

	// Debug routing of the timing and channel pins
	always @*
	begin
		case (dbgSel_ff[`RHS_DBG_SFD_MSB:`RHS_DBG_SFD_LSB])
			2'h0:    sfdSrc = ~state_ff[0];
			2'h1:    sfdSrc = debugSignals[0];
			2'h2:    sfdSrc = debugSignals[1];
			default: sfdSrc = debugSignals[2];
		endcase
	end

	always @*
	begin
		case (dbgSel_ff[`RHS_DBG_CCA_MSB:`RHS_DBG_CCA_LSB])
			2'h0:    ccaSrc = channelClearRaw;
			2'h1:    ccaSrc = debugSignals[0];
			2'h2:    ccaSrc = debugSignals[1];
			default: ccaSrc = debugSignals[2];
		endcase
	end

	// Pins are registered so they change only on the internal clock
	always @(posedge sys_clk or posedge rst)
	begin
		if (rst)
		begin
			rxNonEmptyPin           <= 1'b0;
			rxThresholdPin          <= 1'b0;
			frameDelimiterTimingPin <= 1'b0;
			channelClearPin         <= 1'b0;
		end
		else
		begin
			rxNonEmptyPin <= nonEmptyRaw ^ pinCfg_ff[`RHS_POL_FIFO];
			rxThresholdPin <= thresholdRaw ^ pinCfg_ff[`RHS_POL_RX_THRESHOLD_PIN];
			frameDelimiterTimingPin <= sfdSrc ^ pinCfg_ff[`RHS_POL_SFD];
			channelClearPin <= ccaSrc ^ pinCfg_ff[`RHS_POL_CCA];
		end
	end

	// Edge detection on the synchronised select and serial clock
	assign sclkFall = sclkPrev_ff & ~sclkS;
	assign csFall   = csPrev_ff & ~csLowS;

	always @(posedge sys_clk or posedge rst)
	begin
		if (rst)
		begin
			sclkPrev_ff <= 1'b1;
			csPrev_ff   <= 1'b1;
		end
		else
		begin
			sclkPrev_ff <= sclkS;
			csPrev_ff   <= csLowS;
		end
	end

	// Enable follows the synchronised select, so it trails the pin by three clocks
	always @(posedge sys_clk or posedge rst)
	begin
		if (rst)
			serialDataOe <= 1'b0;
		else
			serialDataOe <= ~csLowS;
	end

	// Serial output stage: status byte shifted MSB first on falling clock
	always @(posedge sys_clk or posedge rst)
	begin
		if (rst)
		begin
			soShift_ff    <= 8'h00;
			soBit_ff      <= 3'h0;
			serialDataOut <= 1'b0;
		end
		else if (csLowS)
		begin
			soBit_ff      <= 3'h0;
			serialDataOut <= 1'b0;
		end
		else if (csFall)
		begin
			soShift_ff    <= {statusByte[6:0], 1'b0};
			serialDataOut <= statusByte[7];
			soBit_ff      <= 3'h1;
		end
		else if (sclkFall)
		begin
			if (soBit_ff == 3'h0)
			begin
				soShift_ff    <= {statusByte[6:0], 1'b0};
				serialDataOut <= statusByte[7];
			end
			else
			begin
				soShift_ff    <= {soShift_ff[6:0], 1'b0};
				serialDataOut <= soShift_ff[7];
			end
			soBit_ff <= soBit_ff + 3'h1;
		end
	end
endmodule // rhs_status_pins

/* verif/rhs_status_pins_sva.sv */
// Checker of the status-pin block port timing
module rhs_status_pins_sva
(
	input logic sys_clk,
	input logic rst,
	input logic regWrEn,
	input logic chipSelectLow,
	input logic rxByteValid,
	input logic rxLengthByte,
	input logic rxSfdDone,
	input logic rxLastByte,
	input logic addrFail,
	input logic receiveFlushStrobe,
	input logic txMode,
	input logic txSfdDone,
	input logic txLastByte,
	input logic txUnderflow,
	input logic rxNonEmptyPin,
	input logic rxThresholdPin,
	input logic frameDelimiterTimingPin,
	input logic serialDataOe
);
	timeunit 1ns;
	timeprecision 1ns;
	// Every legal end of a frame, so a falling timing pin can be traced back
	logic endEv;
	assign endEv = rxLastByte | addrFail | txLastByte | txUnderflow | receiveFlushStrobe;
	default clocking @(posedge sys_clk); endclocking
	default disable iff (rst);
	property p_oeOff; chipSelectLow [*5] |-> !serialDataOe; endproperty
	a_oeOff: assert property (p_oeOff) else $error("serial output driven while deselected");
	property p_sfdRx; rxSfdDone && !txMode |-> ##2 frameDelimiterTimingPin; endproperty
	a_sfdRx: assert property (p_sfdRx) else $error("rx timing pin late");
	// A polarity or debug-routing write may also drop the pin
	property p_sfdEnd; $fell(frameDelimiterTimingPin) |-> $past(endEv, 2) || $past(regWrEn, 2); endproperty
	a_sfdEnd: assert property (p_sfdEnd) else $error("timing pin fell without cause");
	property p_fail; addrFail && !txMode && frameDelimiterTimingPin |-> ##2 !frameDelimiterTimingPin; endproperty
	a_fail: assert property (p_fail) else $error("timing pin kept after filter fail");
	property p_nonEmpty; rxByteValid && rxLengthByte && !txMode && !rxThresholdPin |-> ##2 rxNonEmptyPin; endproperty
	a_nonEmpty: assert property (p_nonEmpty) else $error("non-empty pin late");
	property p_last; rxLastByte && !txMode |-> ##2 rxThresholdPin; endproperty
	a_last: assert property (p_last) else $error("threshold pin missing at packet end");
	property p_sfdTx; txSfdDone && txMode |-> ##2 frameDelimiterTimingPin; endproperty
	a_sfdTx: assert property (p_sfdTx) else $error("tx timing pin late");
	property p_flush; receiveFlushStrobe && !rxByteValid |-> ##2 !rxNonEmptyPin; endproperty
	a_flush: assert property (p_flush) else $error("flush left buffer non-empty");
endmodule // rhs_status_pins_sva
bind rhs_status_pins rhs_status_pins_sva u_sva (.*);

/* verif/rhs_host_model.sv */
// Host controller model driving serial select and clock
module rhs_host_model
(
	input  logic       go,
	input  logic       soLine,
	output logic       chipSelectLow,
	output logic       serialClock,
	output logic [7:0] rxSer,
	output logic       done
);
	timeunit 1ns;
	timeprecision 1ns;
	// Clock stands still outside frames; sampled late in the high phase since the pins are synchronised
	initial
	begin
		chipSelectLow = 1'b1;
		serialClock = 1'b0;
		rxSer = 8'h00;
		done = 1'b0;
		@(posedge go);
		chipSelectLow = 1'b0;
		#1000;
		repeat (8)
		begin
			serialClock = 1'b1;
			#400;
			rxSer = {rxSer[6:0], soLine};
			serialClock = 1'b0;
			#400;
		end
		chipSelectLow = 1'b1;
		done = 1'b1;
	end
endmodule // rhs_host_model

/* verif/rhs_status_pins_tb.sv */
// Self-checking testbench for the status-pin block
`include "rhs_map.vh"
module rhs_status_pins_tb;
	timeunit 1ns;
	timeprecision 1ns;
	localparam V = 0, FRAME_DELIMITER_TIMING_PIN = 1, LAST = 2, PASS = 3, FAIL = 4, DEC = 5, TSFD = 6, TLAST = 7, TUF = 8, FL = 9, RD = 10;
	logic        sys_clk, rst = 1, regWrEn = 0, rxLengthByte = 0, addrFilterEn = 0, autoDiscardEn = 0;
	logic        securedFrame = 0, txMode = 0, channelClearRaw = 0, go = 0, lastSo = 0;
	logic [5:0]  regAddr = 0;
	logic [15:0] regWrData = 0;
	logic [7:0]  rxByte = 0;
	logic [2:0]  debugSignals = 0;
	logic [10:0] pl = 0;
	int          errCount = 0, checksDone = 0, i;
	wire  [15:0] regRdData;
	wire  [7:0]  rdByte, rxSer;
	wire         chipSelectLow, serialClock, rxNonEmptyPin, rxThresholdPin, frameDelimiterTimingPin;
	wire         channelClearPin, serialDataOut, serialDataOe, done, soLine;
	// Released line shows the inverse of its last value, never a lucky match
	assign soLine = serialDataOe ? serialDataOut : ~lastSo;
	always @(posedge sys_clk) if (serialDataOe) lastSo <= serialDataOut;
	rhs_status_pins DUT
	(
		.sys_clk, .rst, .chipSelectLow, .serialClock, .statusByte(8'ha5), .regWrEn, .regAddr, .regWrData, .regRdData,
		.receiveFlushStrobe(pl[FL]), .hostRead(pl[RD]), .rdByte, .rxByteValid(pl[V]), .rxByte, .rxLengthByte,
		.rxSfdDone(pl[FRAME_DELIMITER_TIMING_PIN]), .rxLastByte(pl[LAST]), .addrFilterEn, .autoDiscardEn, .addrPass(pl[PASS]),
		.addrFail(pl[FAIL]), .securedFrame, .decryptDone(pl[DEC]), .txMode, .txSfdDone(pl[TSFD]),
		.txLastByte(pl[TLAST]), .txUnderflow(pl[TUF]), .channelClearRaw, .debugSignals, .rxNonEmptyPin,
		.rxThresholdPin, .frameDelimiterTimingPin, .channelClearPin, .serialDataOut, .serialDataOe
	);
	rhs_host_model host
	(
		.go, .soLine, .chipSelectLow, .serialClock, .rxSer, .done
	);
	initial
	begin
		sys_clk = 1'b0;
		forever #50 sys_clk = ~sys_clk;
	end
	task testDone;
		if (errCount == 0 && checksDone > 0)
			$display("All checks passed");
		else
			$display("Checks failed");
		$finish;
	endtask
	task chk(input logic [15:0] s, input logic [15:0] e);
		checksDone++;
		if (s !== e)
		begin
			errCount++;
			$display("ERROR %0t seen %h expected %h", $time, s, e);
		end
	endtask
	task pulse(input int n);
		@(negedge sys_clk) pl[n] = 1'b1;
		@(negedge sys_clk) pl[n] = 1'b0;
		repeat (2) @(negedge sys_clk);
	endtask
	task wr(input logic [5:0] a, input logic [15:0] d);
		@(negedge sys_clk);
		regAddr = a;
		regWrData = d;
		regWrEn = 1'b1;
		@(negedge sys_clk) regWrEn = 1'b0;
		repeat (2) @(negedge sys_clk);
	endtask
	task rd(input logic [5:0] a, input logic [15:0] e);
		@(negedge sys_clk) regAddr = a;
		repeat (2) @(negedge sys_clk);
		chk(regRdData, e);
	endtask
	task push(input logic [7:0] b, input logic l);
		rxByte = b;
		rxLengthByte = l;
		pulse(V);
	endtask
	task fill(input int n);
		for (i = 0; i < n; i++) push(i[7:0], 1'b0);
	endtask
	task pins(input logic [2:0] e);
		chk({rxNonEmptyPin, rxThresholdPin, frameDelimiterTimingPin}, e);
	endtask
	initial
	begin
		#1000000;
		errCount++;
		testDone;
	end
	initial
	begin
		repeat (8) @(negedge sys_clk);
		rst = 1'b0;
		pins(3'b000);
		rd(`RHS_ADDR_PINCFG, `RHS_PINCFG_RST);
		rd(6'h3f, 16'h0000);
		wr(`RHS_ADDR_PINCFG, 16'h0002);
		rd(`RHS_ADDR_PINCFG, 16'h0002);
		pulse(FRAME_DELIMITER_TIMING_PIN);
		pins(3'b001);
		push(8'h05, 1'b1);
		pins(3'b101);
		fill(2);
		pins(3'b111);
		pulse(LAST);
		pins(3'b110);
		pulse(RD);
		chk(rdByte, 8'h05);
		pulse(RD);
		pulse(RD);
		pins(3'b000);
		addrFilterEn = 1'b1;
		autoDiscardEn = 1'b1;
		pulse(FRAME_DELIMITER_TIMING_PIN);
		push(8'h07, 1'b1);
		fill(3);
		pins(3'b101);
		pulse(FAIL);
		pins(3'b000);
		pulse(FRAME_DELIMITER_TIMING_PIN);
		push(8'h07, 1'b1);
		fill(3);
		pulse(PASS);
		pins(3'b111);
		pulse(FL);
		pulse(FL);
		pins(3'b000);
		addrFilterEn = 1'b0;
		push(8'h01, 1'b1);
		pulse(LAST);
		pins(3'b110);
		pulse(RD);
		pins(3'b000);
		fill(128);
		pins(3'b110);
		push(8'hee, 1'b0);
		pins(3'b010);
		pulse(RD);
		chk(rdByte, 8'h00);
		pulse(FL);
		pulse(FL);
		pins(3'b000);
		wr(`RHS_ADDR_SECCTL, 16'h0200);
		rd(`RHS_ADDR_SECCTL, 16'h0200);
		securedFrame = 1'b1;
		push(8'h09, 1'b1);
		securedFrame = 1'b0;
		pulse(RD);
		fill(128);
		pins(3'b010);
		pulse(DEC);
		pulse(FL);
		pulse(FL);
		wr(`RHS_ADDR_SECCTL, 16'h0000);
		txMode = 1'b1;
		push(8'h33, 1'b1);
		pins(3'b000);
		pulse(TSFD);
		pins(3'b001);
		pulse(TUF);
		pins(3'b000);
		pulse(TSFD);
		pulse(TLAST);
		pins(3'b000);
		txMode = 1'b0;
		wr(`RHS_ADDR_PINCFG, 16'h0782);
		chk({rxNonEmptyPin, rxThresholdPin, frameDelimiterTimingPin, channelClearPin}, 4'hf);
		wr(`RHS_ADDR_PINCFG, 16'h0002);
		channelClearRaw = 1'b1;
		repeat (2) @(negedge sys_clk);
		chk(channelClearPin, 1'b1);
		channelClearRaw = 1'b0;
		debugSignals = 3'b100;
		wr(`RHS_ADDR_DBGSEL, 16'h000f);
		rd(`RHS_ADDR_DBGSEL, 16'h000f);
		chk({frameDelimiterTimingPin, channelClearPin}, 2'b11);
		wr(`RHS_ADDR_DBGSEL, 16'h0000);
		chk({frameDelimiterTimingPin, channelClearPin}, 2'b00);
		chk(serialDataOe, 1'b0);
		go = 1'b1;
		repeat (20) @(negedge sys_clk);
		chk(serialDataOe, 1'b1);
		for (i = 0; i < 200 && !done; i++) @(negedge sys_clk);
		repeat (5) @(negedge sys_clk);
		chk(rxSer, 8'ha5);
		chk(serialDataOe, 1'b0);
		testDone;
	end
endmodule // rhs_status_pins_tb
